// ---- design/tfs_cfg.svh ----
// constants of the test flag serial check unit
`ifndef TFS_CFG_SVH
`define TFS_CFG_SVH

// widths
`define TFS_ACC_W 24
`define TFS_CNT_W 5
`define TFS_PC_W 15
`define TFS_ADDR_W 8

// register byte offsets
`define TFS_OFF_INSTR 8'h00
`define TFS_OFF_ACC 8'h04
`define TFS_OFF_STATUS 8'h08
`define TFS_OFF_PC 8'h0C

// status field positions
`define TFS_ST_FLAG 0
`define TFS_ST_BUSY 1
`define TFS_ST_CARRY 2
`define TFS_ST_CNT_LSB 8
`define TFS_ST_CNT_MSB 12

// command word fields
`define TFS_OPC_MSB 23
`define TFS_OPC_LSB 18
`define TFS_FN_MSB 14
`define TFS_FN_LSB 6
`define TFS_K_MSB 4
`define TFS_OPC_GEN1 6'h05
`define TFS_FN_BITCLR 9'h1C5
`define TFS_FN_SET 9'h1C3
`define TFS_FN_CLR 9'h1C2
`define TFS_WORD_NONZERO 24'h140978

// counts
`define TFS_CNT_END 5'h1F
`define TFS_SHIFTS_LAST 5'h17

// reset values
`define TFS_RST_ACC 24'h000000
`define TFS_RST_IR 24'h000000
`define TFS_RST_PC 15'h0000
`define TFS_RST_CNT 5'h00
`define TFS_RST_DATA 32'h00000000

`endif

// ---- design/tfs_pkg.sv ----
// types of the test flag serial check unit
package tfs_pkg;

  typedef enum logic [1:0] {
    TFS_IDLE,
    TFS_EXEC4,
    TFS_SHIFT,
    TFS_DONE
  } tfs_state_t;

  typedef enum logic [2:0] {
    TFS_OP_NONE,
    TFS_OP_CLR,
    TFS_OP_SET,
    TFS_OP_BITCLR,
    TFS_OP_NONZERO
  } tfs_op_t;

endpackage : tfs_pkg

// ---- design/tfs_serial_adder.sv ----
// one-bit serial full adder
`timescale 1ns/1ps
module tfs_serial_adder import tfs_pkg::*; (
  // operands
  input wire logic in_a,
  input wire logic in_b,
  input wire logic carry_in,
  // results
  output logic sum,
  output logic carry_out
);

  always_comb begin
    sum = in_a ^ in_b ^ carry_in;
    carry_out = (in_a & in_b) | (in_a & carry_in) | (in_b & carry_in);
  end

endmodule : tfs_serial_adder

// ---- design/tfs_shift_counter.sv ----
// five-bit shift counter with load and increment
`timescale 1ns/1ps
`include "tfs_cfg.svh"
module tfs_shift_counter import tfs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [`TFS_CNT_W-1:0] load_value,
  input wire logic inc,
  // value
  output logic [`TFS_CNT_W-1:0] count
);

  typedef struct packed {
    logic [`TFS_CNT_W-1:0] count;
  } tfs_cnt_reg_t;

  tfs_cnt_reg_t r;
  tfs_cnt_reg_t next_r;

  // load wins over increment; wraps at the top
  always_comb begin
    next_r = r;
    if (load) begin
      next_r.count = load_value;
    end else if (inc) begin
      next_r.count = r.count + `TFS_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r.count <= `TFS_RST_CNT;
    end else begin
      r <= next_r;
    end
  end

  assign count = r.count;

endmodule : tfs_shift_counter

// ---- design/tfs_test_flag_unit.sv ----
// test flag serial check unit: command execution with apb register access
`timescale 1ns/1ps
`include "tfs_cfg.svh"
module tfs_test_flag_unit import tfs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TFS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor side
  output logic condition_test_flag,
  output logic busy,
  output logic interrupt_accept,
  output logic [`TFS_PC_W-1:0] program_counter
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    tfs_state_t state;
    tfs_op_t op;
    logic [`TFS_ACC_W-1:0] ir;
    logic [`TFS_ACC_W-1:0] acc;
    logic flag;
    logic carry;
    logic [`TFS_CNT_W-1:0] steps;
    logic [`TFS_PC_W-1:0] pc;
    logic busy;
    logic done_pulse;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tfs_main_reg_t;

  tfs_main_reg_t r;
  tfs_main_reg_t next_r;

  logic [`TFS_CNT_W-1:0] count;
  logic cnt_load;
  logic cnt_inc;
  logic adder_a;
  logic adder_b;
  logic adder_sum;
  logic shifting;
  logic at_end;
  logic access;
  logic wr_take;
  logic rd_take;
  tfs_op_t decoded;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  tfs_shift_counter u_counter (
    .clk(clk),
    .rst(rst),
    .load(cnt_load),
    .load_value(~r.ir[`TFS_K_MSB:0]),
    .inc(cnt_inc),
    .count(count)
  );

  tfs_serial_adder u_adder (
    .in_a(adder_a),
    .in_b(adder_b),
    .carry_in(r.carry),
    .sum(adder_sum),
    .carry_out()
  );

  // command decode of the written word
  always_comb begin
    decoded = TFS_OP_NONE;
    if (pwdata[`TFS_ACC_W-1:0] == `TFS_WORD_NONZERO) begin
      decoded = TFS_OP_NONZERO;
    end else if (pwdata[`TFS_OPC_MSB:`TFS_OPC_LSB] == `TFS_OPC_GEN1) begin
      if (pwdata[`TFS_FN_MSB:`TFS_FN_LSB] == `TFS_FN_BITCLR && !pwdata[5]) begin
        decoded = TFS_OP_BITCLR;
      end else if (pwdata[`TFS_FN_MSB:`TFS_FN_LSB] == `TFS_FN_SET) begin
        decoded = TFS_OP_SET;
      end else if (pwdata[`TFS_FN_MSB:`TFS_FN_LSB] == `TFS_FN_CLR) begin
        decoded = TFS_OP_CLR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath steering

  always_comb begin
    at_end = (count == `TFS_CNT_END);
    // nonzero test stops at the counter end; the others run a fixed 24
    // stop at end
    if (r.op == TFS_OP_NONZERO) begin
      shifting = (r.state == TFS_SHIFT) && !at_end;
    end else begin
      shifting = (r.state == TFS_SHIFT);
    end
    cnt_load = (r.state == TFS_EXEC4);
    cnt_inc = shifting;
    adder_a = (r.op == TFS_OP_BITCLR) ? ~r.acc[0] : r.acc[0];
    adder_b = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    next_r.done_pulse = 1'b0;
    access = psel && penable;
    wr_take = access && r.pready && pwrite;
    rd_take = access && !r.pready && !pwrite;

    case (r.state)
      TFS_IDLE: begin
        next_r.carry = 1'b0;
      end
      TFS_EXEC4: begin
        next_r.steps = `TFS_RST_CNT;
        if (r.op == TFS_OP_CLR) begin
          next_r.flag = 1'b0;
        end
        if (r.op == TFS_OP_SET) begin
          next_r.flag = 1'b1;
        end
        next_r.carry = (r.op == TFS_OP_BITCLR);
        next_r.state = TFS_SHIFT;
      end
      TFS_SHIFT: begin
        if (shifting) begin
          next_r.acc = {adder_sum, r.acc[`TFS_ACC_W-1:1]};
          next_r.steps = r.steps + `TFS_CNT_W'(1);
          if (r.op == TFS_OP_BITCLR && at_end && !r.acc[0]) begin
            next_r.flag = 1'b1;
          end
          if (r.op == TFS_OP_NONZERO && r.acc[0]) begin
            next_r.flag = 1'b1;
          end
          if (r.op != TFS_OP_NONZERO && r.steps == `TFS_SHIFTS_LAST) begin
            next_r.state = TFS_DONE;
          end
        end else begin
          next_r.state = TFS_DONE;
        end
      end
      TFS_DONE: begin
        next_r.pc = r.pc + `TFS_PC_W'(1);
        next_r.carry = 1'b0;
        next_r.busy = 1'b0;
        next_r.done_pulse = 1'b1;
        next_r.state = TFS_IDLE;
      end
      default: begin
        next_r.state = TFS_IDLE;
      end
    endcase

    // apb: pready rises one cycle into the access phase
    next_r.pready = access && !r.pready;
    if (access && !r.pready) begin
      next_r.prdata = `TFS_RST_DATA;
      next_r.pslverr = 1'b0;
      if (paddr == `TFS_OFF_INSTR) begin
        next_r.prdata[`TFS_ACC_W-1:0] = r.ir;
        next_r.pslverr = pwrite && (r.busy || decoded == TFS_OP_NONE);
      end else if (paddr == `TFS_OFF_ACC) begin
        next_r.prdata[`TFS_ACC_W-1:0] = r.acc;
        next_r.pslverr = pwrite && r.busy;
      end else if (paddr == `TFS_OFF_STATUS) begin
        next_r.prdata[`TFS_ST_FLAG] = r.flag;
        next_r.prdata[`TFS_ST_BUSY] = r.busy;
        next_r.prdata[`TFS_ST_CARRY] = r.carry;
        next_r.prdata[`TFS_ST_CNT_MSB:`TFS_ST_CNT_LSB] = count;
        next_r.pslverr = pwrite && r.busy;
      end else if (paddr == `TFS_OFF_PC) begin
        next_r.prdata[`TFS_PC_W-1:0] = r.pc;
        next_r.pslverr = pwrite && r.busy;
      end else begin
        next_r.pslverr = 1'b1;
      end
      if (!rd_take) begin
        next_r.prdata = `TFS_RST_DATA;
      end
    end

    // writes act only at the edge that completes the transfer
    // busy blocks every write, so no write races the command datapath
    if (wr_take && !r.pslverr) begin
      if (paddr == `TFS_OFF_INSTR) begin
        next_r.ir = pwdata[`TFS_ACC_W-1:0];
        next_r.op = decoded;
        next_r.busy = 1'b1;
        next_r.state = TFS_EXEC4;
      end else if (paddr == `TFS_OFF_ACC) begin
        next_r.acc = pwdata[`TFS_ACC_W-1:0];
      end else if (paddr == `TFS_OFF_STATUS) begin
        next_r.flag = pwdata[`TFS_ST_FLAG];
      end else if (paddr == `TFS_OFF_PC) begin
        next_r.pc = pwdata[`TFS_PC_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (rst) begin
      r.state <= TFS_IDLE;
      r.op <= TFS_OP_NONE;
      r.ir <= `TFS_RST_IR;
      r.acc <= `TFS_RST_ACC;
      r.flag <= 1'b0;
      r.carry <= 1'b0;
      r.steps <= `TFS_RST_CNT;
      r.pc <= `TFS_RST_PC;
      r.busy <= 1'b0;
      r.done_pulse <= 1'b0;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
      r.prdata <= `TFS_RST_DATA;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign condition_test_flag = r.flag;
  assign busy = r.busy;
  assign interrupt_accept = r.done_pulse;
  assign program_counter = r.pc;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_force_zero:
    assert property ((r.state == TFS_EXEC4 && r.op == TFS_OP_CLR) |=> !r.flag)
      else $error("force-zero left flag set");

  a_force_one:
    assert property ((r.state == TFS_EXEC4 && r.op == TFS_OP_SET) |=> r.flag && r.state == TFS_SHIFT)
      else $error("force-one did not set flag in state 4");

  a_acc_restored:
    assert property ((r.state == TFS_EXEC4 && r.op != TFS_OP_NONZERO)
      |-> ##25 (r.state == TFS_DONE && r.acc == $past(r.acc, 25)))
      else $error("accumulator not restored after 24 shifts");

  a_acc_rotate:
    assert property (shifting |=> r.acc == {$past(r.acc[0]), $past(r.acc[`TFS_ACC_W-1:1])})
      else $error("accumulator did not rotate through adder");

  a_carry_clear:
    assert property ((r.state == TFS_SHIFT && r.op != TFS_OP_BITCLR) |-> !r.carry)
      else $error("carry set during no-sum command");

  a_carry_held:
    assert property ((r.state == TFS_SHIFT && r.op == TFS_OP_BITCLR) |-> r.carry && adder_sum == r.acc[0])
      else $error("bit-clear adder sum differs from bit 0");

  a_counter_load:
    assert property ((r.state == TFS_EXEC4) |=> count == ~$past(r.ir[`TFS_K_MSB:0]))
      else $error("counter not preset from complement");

  a_counter_step:
    assert property (shifting |=> count == $past(count) + `TFS_CNT_W'(1))
      else $error("counter did not step with shift");

  a_bit_clear_set:
    assert property ((shifting && r.op == TFS_OP_BITCLR && at_end && !r.acc[0]) |=> r.flag)
      else $error("flag not set for clear selected bit");

  a_bit_one_keeps:
    assert property ((shifting && r.op == TFS_OP_BITCLR && !(at_end && !r.acc[0])) |=> r.flag == $past(r.flag))
      else $error("bit-clear changed flag wrongly");

  a_nonzero_set:
    assert property ((shifting && r.op == TFS_OP_NONZERO && r.acc[0]) |=> r.flag)
      else $error("nonzero test missed a one");

  a_nonzero_keeps:
    assert property ((shifting && r.op == TFS_OP_NONZERO && !r.acc[0]) |=> r.flag == $past(r.flag))
      else $error("nonzero test changed flag on a zero");

  // stopping on the counter is what keeps the rotation at exactly 24
  a_shift_stop:
    assert property ((r.state == TFS_SHIFT && r.op == TFS_OP_NONZERO && at_end)
      |=> (r.acc == $past(r.acc) && count == $past(count)))
      else $error("nonzero test shifted past counter end");

  a_nonzero_len:
    assert property ((r.state == TFS_EXEC4 && r.op == TFS_OP_NONZERO)
      |-> ##26 (r.state == TFS_DONE && count == `TFS_CNT_END))
      else $error("nonzero test length wrong");

  a_pc_step:
    assert property ((r.state == TFS_DONE) |=> r.pc == $past(r.pc) + `TFS_PC_W'(1) && interrupt_accept && !busy)
      else $error("program counter or interrupt window wrong");

  a_accept_after_done:
    assert property (interrupt_accept |-> $past(r.state == TFS_DONE) && !busy)
      else $error("interrupt window outside command end");

endmodule : tfs_test_flag_unit

// ---- tb/tfs_test_flag_unit_bench.sv ----
// self-checking bench of the test flag serial check unit
`timescale 1ns/1ps
`include "tfs_cfg.svh"
module tfs_test_flag_unit_bench;
  // clock and reset
  logic clk = 1'b0;
  logic rst = 1'b1;
  // apb master side
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // processor side
  logic condition_test_flag;
  logic busy;
  logic interrupt_accept;
  logic [14:0] program_counter;
  // bookkeeping
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [14:0] pc_exp = 15'h0000;
  logic [31:0] rd;
  logic e;

  tfs_test_flag_unit u_tfs_test_flag_unit (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .condition_test_flag(condition_test_flag),
    .busy(busy),
    .interrupt_accept(interrupt_accept),
    .program_counter(program_counter)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [23:0] cw(input logic [8:0] fn, input logic [4:0] k);
    return {`TFS_OPC_GEN1, 3'h0, fn, 1'b0, k};
  endfunction : cw

  // starts a command; probing status mid-run costs the exact cycle count
  task automatic run_cmd(input logic [23:0] w, input int ncyc, input int early, input int carry);
    int n;
    n = 0;
    apb(1'b1, `TFS_OFF_INSTR, {8'h00, w});
    chk("cmd_err", 32'h0, {31'h0, e});
    #1;
    // set and clear runs start from the opposite flag value
    if (early >= 0) chk("flag_before", 1 - early, {31'h0, condition_test_flag});
    if (carry >= 0) begin
      apb(1'b0, `TFS_OFF_STATUS, 32'h0);
      chk("carry", carry, {31'h0, rd[`TFS_ST_CARRY]});
      apb(1'b1, `TFS_OFF_ACC, 32'h0);
      chk("busy_wr_err", 32'h1, {31'h0, e});
      #1;
    end
    while (busy === 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n == 1 && early >= 0) chk("flag_state4", early, {31'h0, condition_test_flag});
    end
    if (carry < 0) chk("busy_cycles", ncyc, n);
    chk("irq_accept", 32'h1, {31'h0, interrupt_accept});
    pc_exp = pc_exp + 15'h0001;
    chk("pc", {17'h0, pc_exp}, {17'h0, program_counter});
    @(posedge clk);
    #1;
    // the accept window stands for one cycle only
    chk("irq_drop", 32'h0, {31'h0, interrupt_accept});
  endtask : run_cmd

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] offs [4];
    offs = '{`TFS_OFF_INSTR, `TFS_OFF_ACC, `TFS_OFF_STATUS, `TFS_OFF_PC};
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      chk("reset_value", 32'h0, rd);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, rd);
  endtask : t_reset

  // pc starts at the top so the step must wrap to zero
  task automatic t_force();
    apb(1'b1, `TFS_OFF_ACC, 32'h00A5C35A);
    apb(1'b1, `TFS_OFF_PC, 32'h00007FFF);
    pc_exp = 15'h7FFF;
    run_cmd(cw(`TFS_FN_SET, 5'h00), 26, 1, -1);
    chk("set_flag", 32'h1, {31'h0, condition_test_flag});
    run_cmd(cw(`TFS_FN_CLR, 5'h1F), 26, 0, -1);
    chk("clr_flag", 32'h0, {31'h0, condition_test_flag});
    apb(1'b0, `TFS_OFF_ACC, 32'h0);
    chk("force_acc", 32'h00A5C35A, rd);
  endtask : t_force

  task automatic t_bitclr();
    logic [23:0] a;
    logic [4:0] ks [5];
    logic pre [5];
    a = 24'h5A3C81;
    ks = '{5'h00, 5'h05, 5'h17, 5'h07, 5'h00};
    pre = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    apb(1'b1, `TFS_OFF_ACC, {8'h00, a});
    foreach (ks[i]) begin
      apb(1'b1, `TFS_OFF_STATUS, {31'h0, pre[i]});
      run_cmd(cw(`TFS_FN_BITCLR, ks[i]), 26, -1, -1);
      chk("bitclr_flag", {31'h0, pre[i] | ~a[ks[i]]}, {31'h0, condition_test_flag});
      apb(1'b0, `TFS_OFF_STATUS, 32'h0);
      // 27 octal minus the bit number
      chk("bitclr_count", {27'h0, 5'h17 - ks[i]}, {27'h0, rd[12:8]});
      apb(1'b0, `TFS_OFF_ACC, 32'h0);
      chk("bitclr_acc", {8'h00, a}, rd);
    end
  endtask : t_bitclr

  task automatic t_nonzero();
    logic [23:0] vs [4];
    vs = '{24'h000000, 24'h800000, 24'h000001, 24'h000000};
    // last pass presets the flag so an all-zero word must leave it set
    foreach (vs[i]) begin
      apb(1'b1, `TFS_OFF_ACC, {8'h00, vs[i]});
      apb(1'b1, `TFS_OFF_STATUS, {31'h0, i == 3});
      run_cmd(`TFS_WORD_NONZERO, 27, -1, -1);
      chk("nz_flag", {31'h0, (i == 3) | (|vs[i])}, {31'h0, condition_test_flag});
      apb(1'b0, `TFS_OFF_STATUS, 32'h0);
      chk("nz_count", 32'h1F, {27'h0, rd[12:8]});
      apb(1'b0, `TFS_OFF_ACC, 32'h0);
      chk("nz_acc", {8'h00, vs[i]}, rd);
    end
  endtask : t_nonzero

  // carry read mid-run; a write during the run must not land
  task automatic t_probe();
    apb(1'b1, `TFS_OFF_ACC, 32'h00123456);
    run_cmd(cw(`TFS_FN_BITCLR, 5'h03), 0, -1, 1);
    run_cmd(`TFS_WORD_NONZERO, 0, -1, 0);
    run_cmd(cw(`TFS_FN_SET, 5'h00), 0, -1, 0);
    apb(1'b0, `TFS_OFF_ACC, 32'h0);
    chk("acc_refused", 32'h00123456, rd);
    apb(1'b1, `TFS_OFF_INSTR, 32'h00FFFFFF);
    chk("bad_cmd_err", 32'h1, {31'h0, e});
    apb(1'b0, `TFS_OFF_PC, 32'h0);
    chk("pc_hold", {17'h0, pc_exp}, rd);
  endtask : t_probe

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_force();
    t_bitclr();
    t_nonzero();
    t_probe();
    end_sim();
  end
endmodule : tfs_test_flag_unit_bench
